// file: hdl/hvs_video_ctl.sv
// Video sync, blanking, shift clock gating and host strobe top level
`timescale 1ns/1ps
`default_nettype none
module hvs_video_ctl #(
  parameter int unsigned PIPE_DEPTH = hvs_pkg::PIPE_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pixel_load_strobe,
  input  wire logic [29:0] pixel_data_in,
  input  wire logic        blank_n,
  input  wire logic        sync_n,
  input  wire logic        three_level_sync_ctl,
  input  wire logic        field_parity,
  input  wire logic        shift_clock_in,
  input  wire logic        pll_reference_clock_in,
  output logic             gated_shift_clock_out,
  output logic             delayed_sync_out,
  output logic      [29:0] colour_current_outputs,
  output logic             field_parity_out,
  output logic             pll_clock_out,
  input  wire logic        chip_enable_n,
  input  wire logic        read_write,
  input  wire logic [1:0]  command_select,
  input  wire logic [9:0]  host_data_in,
  output logic      [9:0]  host_data_out,
  output logic             host_data_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [6:0]  ctrl;
  logic [7:0]  pll_div;
  logic [9:0]  rd_word;
  logic [9:0]  last_word;
  logic [1:0]  last_cmd;
  logic        host_new;
  logic        apb_acc;
  logic        apb_wr;
  logic        three_level_sync_en;
  logic        sync_on_green_en;
  logic        sync_on_red_en;
  logic        sync_on_blue_en;
  logic        interlace_en;

  hvs_host_if hif ();

  assign three_level_sync_en = ctrl[hvs_pkg::CTRL_TRI];
  assign sync_on_green_en    = ctrl[hvs_pkg::CTRL_SOG];
  assign sync_on_red_en      = ctrl[hvs_pkg::CTRL_SOR];
  assign sync_on_blue_en     = ctrl[hvs_pkg::CTRL_SOB];
  assign interlace_en        = ctrl[hvs_pkg::CTRL_ILACE];
  assign hif.mode    = hvs_pkg::hvs_width_t'(ctrl[hvs_pkg::CTRL_WID +: 2]);
  assign hif.rd_word = rd_word;

  // Access phase before the answer; write lands when pready is seen
  assign apb_acc = psel & penable & ~pready;
  assign apb_wr  = psel & penable & pready & pwrite;

  always_ff @(posedge ref_clk) begin
    if (srst) pready <= 1'h0;
    else pready <= apb_acc;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'h0;
    end else if (apb_acc) begin
      pslverr <= 1'h0;
      prdata  <= 32'h0000_0000;
      if (paddr == hvs_pkg::ADDR_CTRL) begin
        prdata <= {25'h000_0000, ctrl};
      end else if (paddr == hvs_pkg::ADDR_PLL) begin
        prdata <= {24'h00_0000, pll_div};
      end else if (paddr == hvs_pkg::ADDR_HOST) begin
        prdata <= {19'h0_0000, host_new, last_cmd, last_word};
      end else if (paddr == hvs_pkg::ADDR_RDBK) begin
        prdata <= {22'h00_0000, rd_word};
      end else begin
        pslverr <= 1'h1;
      end
    end else begin
      pslverr <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl    <= hvs_pkg::CTRL_RST;
      pll_div <= hvs_pkg::PLL_RST;
      rd_word <= 10'h000;
    end else if (apb_wr) begin
      if (paddr == hvs_pkg::ADDR_CTRL) begin
        ctrl <= pwdata[hvs_pkg::CTRL_BITS-1:0];
      end else if (paddr == hvs_pkg::ADDR_PLL) begin
        pll_div <= pwdata[7:0];
      end else if (paddr == hvs_pkg::ADDR_RDBK) begin
        rd_word <= pwdata[9:0];
      end
    end
  end

  // Host write record; a new write wins over the clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      last_word <= 10'h000;
      last_cmd  <= 2'h0;
      host_new  <= 1'h0;
    end else if (hif.wr_pulse) begin
      last_word <= hif.wr_word;
      last_cmd  <= hif.wr_cmd;
      host_new  <= 1'h1;
    end else if (apb_wr && paddr == hvs_pkg::ADDR_HOST &&
                 pwdata[hvs_pkg::HOST_NEW]) begin
      host_new <= 1'h0;
    end
  end

  hvs_host_port u_host (
    .ref_clk        (ref_clk),
    .srst           (srst),
    .chip_enable_n  (chip_enable_n),
    .read_write     (read_write),
    .command_select (command_select),
    .host_data_in   (host_data_in),
    .host_data_out  (host_data_out),
    .host_data_oe   (host_data_oe),
    .hif            (hif.port)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pixel-rate sampling and pipeline

  logic        ld_q;
  logic        ld_edge;
  logic [33:0] p_in;
  logic [33:0] p_out;
  logic [29:0] p_pix;
  logic        p_blank_n;
  logic        p_sync_n;
  logic        p_tri_n;
  logic        p_par;

  always_ff @(posedge ref_clk) begin
    if (srst) ld_q <= 1'h0;
    else ld_q <= pixel_load_strobe;
  end

  assign ld_edge = pixel_load_strobe & ~ld_q;
  assign p_in = {field_parity, three_level_sync_ctl, sync_n, blank_n,
                 pixel_data_in};

  hvs_pipe #(
    .W     (34),
    .DEPTH (PIPE_DEPTH),
    .RST   ({4'h6, 30'h0000_0000})
  ) u_pipe (
    .ref_clk (ref_clk),
    .srst    (srst),
    .advance (ld_edge),
    .din     (p_in),
    .dout    (p_out)
  );

  assign p_pix     = p_out[29:0];
  assign p_blank_n = p_out[30];
  assign p_sync_n  = p_out[31];
  assign p_tri_n   = p_out[32];
  assign p_par     = p_out[33];

  ////////////////////////////////////////////////////////////////////////
  // Colour level selection

  function automatic logic [9:0] hvs_level(
    input logic       en,
    input logic [9:0] pix
  );
    if (en && !p_sync_n) begin
      return hvs_pkg::SYNC_LEVEL;
    end else if (en && three_level_sync_en && !p_tri_n) begin
      return hvs_pkg::TRI_LEVEL;
    end else if (!p_blank_n) begin
      return hvs_pkg::BLANK_LEVEL;
    end else begin
      return pix;
    end
  endfunction : hvs_level

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      colour_current_outputs <= {3{hvs_pkg::BLANK_LEVEL}};
    end else begin
      colour_current_outputs <= {hvs_level(sync_on_red_en, p_pix[29:20]),
                                 hvs_level(sync_on_green_en, p_pix[19:10]),
                                 hvs_level(sync_on_blue_en, p_pix[9:0])};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) delayed_sync_out <= 1'h1;
    else delayed_sync_out <= p_sync_n;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) field_parity_out <= 1'h0;
    else field_parity_out <= interlace_en & p_par;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift clock gating

  logic sck_gate;

  always_ff @(posedge ref_clk) begin
    if (srst) sck_gate <= 1'h0;
    else if (!shift_clock_in) sck_gate <= p_blank_n;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) gated_shift_clock_out <= 1'h0;
    else gated_shift_clock_out <= shift_clock_in & sck_gate;
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock generator from the reference input

  logic       pr_q;
  logic       pr_edge;
  logic [7:0] pll_cnt;

  always_ff @(posedge ref_clk) begin
    if (srst) pr_q <= 1'h0;
    else pr_q <= pll_reference_clock_in;
  end

  assign pr_edge = pll_reference_clock_in & ~pr_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pll_cnt       <= 8'h00;
      pll_clock_out <= 1'h0;
    end else if (pr_edge) begin
      if (pll_cnt >= pll_div) begin
        pll_cnt       <= 8'h00;
        pll_clock_out <= ~pll_clock_out;
      end else begin
        pll_cnt <= pll_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_sck_closed;
    !shift_clock_in && !p_blank_n ##1 shift_clock_in;
  endsequence

  sequence s_blank_only;
    !p_blank_n && p_sync_n && p_tri_n;
  endsequence

  AST_SCK_STOP: assert property (
    s_sck_closed |=> !gated_shift_clock_out)
    else $error("Shift clock ran during blanking");

  AST_SCK_CLEAN: assert property (
    $rose(gated_shift_clock_out) |->
      $past(shift_clock_in) && !$past(shift_clock_in, 2))
    else $error("Shift clock output started mid pulse");

  AST_BLANK_LEVEL: assert property (
    s_blank_only |=> colour_current_outputs == {3{hvs_pkg::BLANK_LEVEL}})
    else $error("Blank did not force blanking level");

  AST_SYNC_GREEN: assert property (
    (!p_sync_n && sync_on_green_en) |=>
      colour_current_outputs[19:10] == hvs_pkg::SYNC_LEVEL)
    else $error("Enabled sync missing on green");

  AST_SYNC_IGNORED: assert property (
    (ctrl[3:1] == 3'h0 && !p_blank_n) |=>
      colour_current_outputs == {3{hvs_pkg::BLANK_LEVEL}})
    else $error("Sync used with no colour enabled");

  AST_SYNC_DELAY: assert property (
    $changed(delayed_sync_out) |-> $past(ld_edge, 2))
    else $error("Delayed sync moved off the pipeline");

  AST_TRI_OFF: assert property (
    (!three_level_sync_en && sync_on_green_en && p_sync_n && !p_blank_n)
      |=> colour_current_outputs[19:10] == hvs_pkg::BLANK_LEVEL)
    else $error("Tri-sync acted while disabled");

  AST_TRI_LEVEL: assert property (
    (three_level_sync_en && !p_tri_n && p_sync_n && sync_on_red_en)
      |=> colour_current_outputs[29:20] == hvs_pkg::TRI_LEVEL)
    else $error("Red not at tri-sync level");

  AST_FIELD_OFF: assert property (
    !interlace_en |=> !field_parity_out)
    else $error("Field parity passed when noninterlaced");

  AST_PLL_STEP: assert property (
    $changed(pll_clock_out) |-> $past(pr_edge))
    else $error("Generated clock moved without a reference edge");

endmodule : hvs_video_ctl
`default_nettype wire

// file: hdl/hvs_pkg.sv
// Constants, types and register map of the video sync and host strobe block
// Operation
// - Shift clock out is shift clock in, gated synchronously by blanking.
// - Reference input drives a clock generator set by its own registers.
// - Blank active forces every colour output not driven by sync or tri-sync to the blanking level.
// - Sync reaches a colour only if its enable is set; else ignored.
// - Delayed sync output copies sync input after the pipeline delay.
// - Three-level sync input acts only when its enable bit is set.
// - Three-level sync low drives sync-enabled colours to tri-sync level.
// - Host bus is 10 bits, split 8+2, or plain 8 bits.
// - Field parity used in interlaced mode, ignored when noninterlaced.
// - Host write data captured on the rising edge of chip enable.
// - Blank, sync, tri-sync and parity sampled with pixels on load.
// - Command select latched on the falling edge of chip enable.
package hvs_pkg;

  // APB register offsets
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_PLL   = 12'h004;
  localparam logic [11:0] ADDR_HOST  = 12'h008;
  localparam logic [11:0] ADDR_RDBK  = 12'h00C;

  // Control register fields
  localparam int unsigned CTRL_TRI   = 0;
  localparam int unsigned CTRL_SOG   = 1;
  localparam int unsigned CTRL_SOR   = 2;
  localparam int unsigned CTRL_SOB   = 3;
  localparam int unsigned CTRL_ILACE = 4;
  localparam int unsigned CTRL_WID   = 5;
  localparam int unsigned CTRL_BITS  = 7;
  localparam logic [6:0]  CTRL_RST   = 7'h00;
  localparam logic [7:0]  PLL_RST    = 8'h00;
  localparam int unsigned HOST_NEW   = 12;

  // Pipeline depth from load strobe to outputs
  localparam int unsigned PIPE_DEPTH = 3;

  // Output level codes
  localparam logic [9:0] SYNC_LEVEL  = 10'h000;
  localparam logic [9:0] BLANK_LEVEL = 10'h040;
  localparam logic [9:0] TRI_LEVEL   = 10'h080;

  typedef enum logic [1:0] {
    WID_10  = 2'b00,
    WID_8P2 = 2'b01,
    WID_8   = 2'b10
  } hvs_width_t;

  typedef enum logic {
    BYTE_LO = 1'b0,
    BYTE_HI = 1'b1
  } hvs_byte_t;

endpackage : hvs_pkg

// file: hdl/hvs_host_if.sv
// Carrier between the core and the host data bus port
`timescale 1ns/1ps
`default_nettype none
interface hvs_host_if;
  hvs_pkg::hvs_width_t mode;
  logic [9:0]          rd_word;
  logic [9:0]          wr_word;
  logic [1:0]          wr_cmd;
  logic                wr_pulse;
  modport port (input mode, input rd_word,
                output wr_word, output wr_cmd, output wr_pulse);
  modport core (output mode, output rd_word,
                input wr_word, input wr_cmd, input wr_pulse);
endinterface : hvs_host_if
`default_nettype wire

// file: hdl/hvs_pipe.sv
// Strobe-advanced delay line for pixel data and video controls
`timescale 1ns/1ps
`default_nettype none
module hvs_pipe #(
  parameter int unsigned    W     = 34,
  parameter int unsigned    DEPTH = 3,
  parameter logic [W-1:0]   RST   = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic         advance,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) stage[i] <= RST;
    end else if (advance) begin
      stage[0] <= din;
      for (int i = 1; i < DEPTH; i++) stage[i] <= stage[i-1];
    end
  end

  assign dout = stage[DEPTH-1];
endmodule : hvs_pipe
`default_nettype wire

// file: hdl/hvs_host_port.sv
// Host data bus port: chip enable strobes, width modes, read drive
`timescale 1ns/1ps
`default_nettype none
module hvs_host_port (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       chip_enable_n,
  input  wire logic       read_write,
  input  wire logic [1:0] command_select,
  input  wire logic [9:0] host_data_in,
  output logic      [9:0] host_data_out,
  output logic            host_data_oe,
  hvs_host_if.port        hif
);
  logic                ce_q;
  logic                rd_q;
  logic [1:0]          cmd_q;
  logic [7:0]          lo_byte;
  hvs_pkg::hvs_byte_t  wphase;
  hvs_pkg::hvs_byte_t  rphase;
  logic                ce_fall;
  logic                ce_rise;

  assign ce_fall = ce_q & ~chip_enable_n;
  assign ce_rise = ~ce_q & chip_enable_n;

  always_ff @(posedge ref_clk) begin
    if (srst) ce_q <= 1'h1;
    else ce_q <= chip_enable_n;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmd_q <= 2'h0;
      rd_q  <= 1'h0;
    end else if (ce_fall) begin
      cmd_q <= command_select;
      rd_q  <= read_write;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wphase       <= hvs_pkg::BYTE_LO;
      lo_byte      <= 8'h00;
      hif.wr_word  <= 10'h000;
      hif.wr_cmd   <= 2'h0;
      hif.wr_pulse <= 1'h0;
    end else begin
      hif.wr_pulse <= 1'h0;
      if (ce_rise && !rd_q) begin
        hif.wr_cmd <= cmd_q;
        if (hif.mode == hvs_pkg::WID_10) begin
          hif.wr_word  <= host_data_in;
          hif.wr_pulse <= 1'h1;
        end else if (hif.mode == hvs_pkg::WID_8P2) begin
          case (wphase)
            hvs_pkg::BYTE_LO: begin
              lo_byte <= host_data_in[7:0];
              wphase  <= hvs_pkg::BYTE_HI;
            end
            default: begin
              hif.wr_word  <= {host_data_in[1:0], lo_byte};
              hif.wr_pulse <= 1'h1;
              wphase       <= hvs_pkg::BYTE_LO;
            end
          endcase
        end else begin
          hif.wr_word  <= {host_data_in[7:0], 2'h0};
          hif.wr_pulse <= 1'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      host_data_oe  <= 1'h0;
      host_data_out <= 10'h000;
      rphase        <= hvs_pkg::BYTE_LO;
    end else if (ce_fall && read_write) begin
      host_data_oe <= 1'h1;
      if (hif.mode == hvs_pkg::WID_10) begin
        host_data_out <= hif.rd_word;
      end else if (hif.mode == hvs_pkg::WID_8P2) begin
        case (rphase)
          hvs_pkg::BYTE_LO: host_data_out <= {2'h0, hif.rd_word[7:0]};
          default:          host_data_out <= {8'h00, hif.rd_word[9:8]};
        endcase
      end else begin
        host_data_out <= {2'h0, hif.rd_word[9:2]};
      end
    end else if (ce_rise) begin
      host_data_oe <= 1'h0;
      if (rd_q && hif.mode == hvs_pkg::WID_8P2) begin
        rphase <= (rphase == hvs_pkg::BYTE_LO) ? hvs_pkg::BYTE_HI
                                              : hvs_pkg::BYTE_LO;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_full_write;
    ce_rise && !rd_q && hif.mode == hvs_pkg::WID_10;
  endsequence

  AST_HOST_WR: assert property (
    s_full_write |=> hif.wr_pulse && hif.wr_word == $past(host_data_in))
    else $error("Host write not captured at chip enable rise");

  AST_BYTE_PAIR: assert property (
    (ce_rise && !rd_q && hif.mode == hvs_pkg::WID_8P2 &&
     wphase == hvs_pkg::BYTE_LO) |=> !hif.wr_pulse)
    else $error("Low byte alone produced a word");

  AST_CMD_HELD: assert property (
    ce_fall ##1 (chip_enable_n == 1'h0)[*2] |-> $stable(cmd_q))
    else $error("Command changed inside an access");
endmodule : hvs_host_port
`default_nettype wire

// file: bench/hvs_host_model.sv
// Host processor model driving the chip enable data bus
`timescale 1ns/1ps
`default_nettype none
module hvs_host_model (
  input  wire logic ref_clk,
  output logic       chip_enable_n,
  output logic       read_write,
  output logic [1:0] command_select,
  output logic [9:0] host_data_in
);
  initial begin
    chip_enable_n = 1'b1;
    read_write = 1'b1;
    command_select = 2'h0;
    host_data_in = 10'h155;
  end
  task automatic access(input logic rd, input logic [1:0] c,
                        input logic [9:0] d);
    @(posedge ref_clk);
    chip_enable_n <= 1'b0;
    read_write <= rd;
    command_select <= c;
    host_data_in <= ~d;
    @(posedge ref_clk);
    command_select <= ~c;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chip_enable_n <= 1'b1;
    host_data_in <= d;
    @(posedge ref_clk);
    host_data_in <= ~d;
  endtask : access
endmodule : hvs_host_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the video sync and host strobe block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk = 1'b0, srst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, host_data_oe, pll_clock_out;
  logic        pixel_load_strobe = 1'b0, blank_n = 1'b0, sync_n = 1'b1;
  logic        three_level_sync_ctl = 1'b1, field_parity = 1'b0;
  logic        shift_clock_in = 1'b0, pll_reference_clock_in = 1'b0;
  logic [29:0] pixel_data_in = 30'h0, colour_current_outputs;
  logic        gated_shift_clock_out, delayed_sync_out, field_parity_out;
  logic        chip_enable_n, read_write;
  logic [1:0]  command_select;
  logic [9:0]  host_data_in, host_data_out;
  logic [33:0] apb_q[$];
  logic [31:0] vid_q[$];
  logic [9:0]  hst_q[$];
  int          err_total = 0, total_checks = 0;
  logic [15:0] lfsr = 16'h4789;
  logic        prev_oe = 1'b0, p1 = 1'b0, sck_chk = 1'b0, sck_open = 1'b0;
  logic        par_exp = 1'b0;
  event        vid_ev;

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    shift_clock_in <= ~shift_clock_in;
    pll_reference_clock_in <= ~pll_reference_clock_in;
  end

  hvs_video_ctl #(.PIPE_DEPTH(3)) i_hvs_video_ctl (.ref_clk, .srst, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .pixel_load_strobe, .pixel_data_in, .blank_n, .sync_n,
    .three_level_sync_ctl, .field_parity, .shift_clock_in,
    .pll_reference_clock_in, .gated_shift_clock_out, .delayed_sync_out,
    .colour_current_outputs, .field_parity_out, .pll_clock_out,
    .chip_enable_n, .read_write, .command_select, .host_data_in,
    .host_data_out, .host_data_oe);
  hvs_host_model i_hvs_host_model (.ref_clk, .chip_enable_n, .read_write,
    .command_select, .host_data_in);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [29:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return {lfsr[13:0], lfsr};
  endfunction : rnd

  // Expected colour codes, sync over tri-sync over blank
  function automatic logic [29:0] col(input logic [2:0] en,
      input logic b, s, t, te, input logic [29:0] px);
    for (int i = 0; i < 3; i++)
      col[i*10 +: 10] = (en[i] && !s) ? hvs_pkg::SYNC_LEVEL :
        (en[i] && te && !t) ? hvs_pkg::TRI_LEVEL :
        !b ? hvs_pkg::BLANK_LEVEL : px[i*10 +: 10];
  endfunction : col

  task automatic check(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // Note is {is_read, slverr, data}
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [33:0] note);
    int n;
    apb_q.push_back(note);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic load(input logic b, s, t, input logic [29:0] px);
    @(posedge ref_clk);
    pixel_load_strobe <= 1'b1;
    blank_n <= b;
    sync_n <= s;
    three_level_sync_ctl <= t;
    pixel_data_in <= px;
    @(posedge ref_clk);
    pixel_load_strobe <= 1'b0;
  endtask : load

  task automatic note(input logic [30:0] e);
    vid_q.push_back({par_exp, e});
    cyc(3);
    -> vid_ev;
  endtask : note

  task automatic vid(input logic b, s, t, input logic [29:0] px,
                     input logic [30:0] e);
    repeat (3) load(b, s, t, px);
    note(e);
  endtask : vid

  task automatic pll_run(input logic [7:0] dv);
    int   n;
    logic v;
    apb(1, hvs_pkg::ADDR_PLL, {24'h0, dv}, 34'h0);
    apb(0, hvs_pkg::ADDR_PLL, 0, {2'b10, 24'h0, dv});
    repeat (2) begin
      v = pll_clock_out;
      n = 0;
      do begin
        cyc(1);
        n++;
      end while (pll_clock_out === v && n < 600);
      if (n >= 600) begin
        err_total++;
        summarize();
      end
    end
    check(n, 2 * (int'(dv) + 1), "pll");
  endtask : pll_run

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    logic [33:0] nt;
    if (pready === 1'b1 && apb_q.size() > 0) begin
      nt = apb_q.pop_front();
      check({31'h0, pslverr}, {31'h0, nt[32]}, "slverr");
      if (nt[33])
        check(prdata, nt[31:0], "prdata");
    end
    if (host_data_oe === 1'b1 && prev_oe !== 1'b1 && hst_q.size() > 0)
      check({22'h0, host_data_out}, {22'h0, hst_q.pop_front()},
            "host");
    if (sck_chk)
      check({31'h0, gated_shift_clock_out}, {31'h0, p1 & sck_open},
            "sck");
    prev_oe <= host_data_oe;
    p1 <= shift_clock_in;
  end
  always @(vid_ev)
    check({field_parity_out, delayed_sync_out, colour_current_outputs},
          vid_q.pop_front(), "video");

  initial begin
    cyc(60000);
    err_total++;
    summarize();
  end

  initial begin
    logic [29:0] px;
    logic [9:0]  d;
    logic        b, s, t;
    cyc(4);
    srst <= 1'b0;
    apb(0, hvs_pkg::ADDR_CTRL, 0, {2'b10, 32'h0});
    apb(0, hvs_pkg::ADDR_HOST, 0, {2'b10, 32'h0});
    apb(1, 12'h010, 32'hF, {2'b01, 32'h0});
    apb(0, 12'h010, 0, {2'b11, 32'h0});
    px = rnd();
    for (int e = 0; e < 16; e++) begin
      apb(1, hvs_pkg::ADDR_CTRL, {28'h0, e[3:0]}, 34'h0);
      apb(0, hvs_pkg::ADDR_CTRL, 0, {2'b10, 28'h0, e[3:0]});
      for (int k = 0; k < 5; k++) begin
        // Sync and tri-sync only while blanked
        b = (k == 4);
        s = k[0] | b;
        t = k[1] | b;
        px = rnd();
        vid(b, s, t, px, {s, col({e[2], e[1], e[3]}, b, s, t, e[0], px)});
      end
    end
    vid(0, 1, 1, px, {1'b1, col(3'h7, 0, 1, 1, 1, px)});
    load(0, 0, 1, px);
    load(0, 1, 1, px);
    note({1'b1, col(3'h7, 0, 1, 1, 1, px)});
    load(0, 1, 1, px);
    note({1'b0, col(3'h7, 0, 0, 1, 1, px)});
    load(0, 1, 1, px);
    note({1'b1, col(3'h7, 0, 1, 1, 1, px)});
    sck_open <= 1'b0;
    sck_chk <= 1'b1;
    cyc(16);
    sck_chk <= 1'b0;
    vid(1, 1, 1, px, {1'b1, px});
    sck_open <= 1'b1;
    sck_chk <= 1'b1;
    cyc(16);
    sck_chk <= 1'b0;
    apb(1, hvs_pkg::ADDR_CTRL, 32'h10, 34'h0);
    for (int f = 1; f < 6; f++) begin
      load(0, 1, 1, px);
      field_parity <= f[0];
      par_exp = f[0];
      vid(0, 1, 1, px, {1'b1, {3{hvs_pkg::BLANK_LEVEL}}});
      vid(1, 1, 1, px, {1'b1, px});
    end
    par_exp = 1'b0;
    apb(1, hvs_pkg::ADDR_CTRL, 32'h0, 34'h0);
    vid(1, 1, 1, px, {1'b1, px});
    pll_run(8'h02);
    pll_run({4'h0, px[3:0]});
    d = px[9:0];
    apb(1, hvs_pkg::ADDR_RDBK, {22'h0, d}, 34'h0);
    apb(0, hvs_pkg::ADDR_RDBK, 0, {2'b10, 22'h0, d});
    apb(1, hvs_pkg::ADDR_CTRL, 32'h20, 34'h0);
    i_hvs_host_model.access(0, 2'h3, d);
    i_hvs_host_model.access(0, 2'h3, {8'h00, d[9:8]});
    cyc(3);
    apb(0, hvs_pkg::ADDR_HOST, 0, {2'b10, 19'h0, 1'b1, 2'h3, d});
    hst_q.push_back({2'h0, d[7:0]});
    hst_q.push_back({8'h00, d[9:8]});
    repeat (2) i_hvs_host_model.access(1, 2'h1, 10'h0);
    apb(1, hvs_pkg::ADDR_CTRL, 32'h0, 34'h0);
    i_hvs_host_model.access(0, 2'h2, ~d);
    cyc(3);
    apb(0, hvs_pkg::ADDR_HOST, 0, {2'b10, 19'h0, 1'b1, 2'h2, ~d});
    apb(1, hvs_pkg::ADDR_HOST, 32'h1000, 34'h0);
    apb(0, hvs_pkg::ADDR_HOST, 0, {2'b10, 19'h0, 1'b0, 2'h2, ~d});
    hst_q.push_back(d);
    i_hvs_host_model.access(1, 2'h1, 10'h0);
    apb(1, hvs_pkg::ADDR_CTRL, 32'h40, 34'h0);
    i_hvs_host_model.access(0, 2'h1, d);
    cyc(3);
    apb(0, hvs_pkg::ADDR_HOST, 0, {2'b10, 19'h0, 1'b1, 2'h1, d[7:0], 2'h0});
    hst_q.push_back({2'h0, d[9:2]});
    i_hvs_host_model.access(1, 2'h1, 10'h0);
    cyc(4);
    if (apb_q.size() + vid_q.size() + hst_q.size() != 0)
      err_total++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
